// *** verilog/amsq_params.svh ***
// Constants of the serial mode sequencer: frame lengths, field positions,
// register offsets and reset values. Included by bare name by design files.
`ifndef AMSQ_PARAMS_SVH
`define AMSQ_PARAMS_SVH
// Frame shape in serial clocks
`define AMSQ_CTRL_BITS  8
`define AMSQ_RES_BITS   16
`define AMSQ_SHORT_PER  24
`define AMSQ_LONG_PER   32
// Acquisition ends on this falling edge after the start bit
`define AMSQ_ACQ_SHORT  6
`define AMSQ_ACQ_LONG   14
`define AMSQ_START_SEED 8'h01
// Bit positions in the complete control byte
`define AMSQ_POS_UNI    6
`define AMSQ_POS_CLK    5
`define AMSQ_POS_M1     4
`define AMSQ_POS_M0     3
// Bit positions in the partial byte at the sixth falling edge
`define AMSQ_ACQ_UNI    4
`define AMSQ_ACQ_M1     2
`define AMSQ_ACQ_M0     1
// Register byte offsets
`define AMSQ_REG_CTRL   5'h00
`define AMSQ_REG_STAT   5'h04
`define AMSQ_REG_IRQST  5'h08
`define AMSQ_REG_IRQMSK 5'h0c
`define AMSQ_REG_RESULT 5'h10
// Reset values
`define AMSQ_CTRL_RST   1'b1
`define AMSQ_PIN_RST    5'h1a
// Event bit positions
`define AMSQ_EV_CONV    0
`define AMSQ_EV_CALDONE 1
`define AMSQ_EV_ABORT   2
`define AMSQ_EV_POWER_DOWN_PIN_N    3
`endif

// *** verilog/amsq_pkg.sv ***
// Types of the serial mode sequencer.
// Assumes amsq_params.svh holds the frame, field and register constants.
package amsq_pkg;
  // One-hot sequencer states
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RECV = 6'h02,
    ST_CONV = 6'h04,
    ST_OUT  = 6'h08,
    ST_CAL  = 6'h10,
    ST_POWER_DOWN_PIN_N = 6'h20
  } amsq_state_t;

  // Fields latched from a control byte
  typedef struct packed {
    logic       polarity_select;
    logic       ext_clk;
    logic       mode_select_high;
    logic       mode_select_low;
    logic [2:0] user_out;
  } amsq_ctrl_t;

  // Pins after synchronisation
  typedef struct packed {
    logic rst_pin_n;
    logic pdn_n;
    logic din;
    logic cs_n;
    logic sclk;
  } amsq_pins_t;
endpackage

// *** verilog/amsq_sync.sv ***
// Two-stage synchroniser for a group of asynchronous pins.
// Assumes a synchronous active-low reset on the sampling clock.
module amsq_sync #(
  parameter int unsigned   W       = 5,
  parameter logic [W-1:0]  RST_VAL = '0
) (
  input  logic         clk_sys_i,
  input  logic         rst_n_i,
  input  logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  // First stage feeds only the second one
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;
endmodule

// *** verilog/amsq_top.sv ***
// Serial control and mode sequencer of a sampling converter, Avalon-MM regs.
// Assumes serial pins come from another domain; sample_data_i from core.
//
// Function
// - A short conversion fits three byte transfers: control byte, then two result bytes; a long one takes four.
// - Link is full duplex: bits shift in and out on the same clock.
// - Mode 00: acquisition 5.5 clocks, conversion period 24 clocks.
// - Mode 11: acquisition 13.5 clocks, conversion period 32 clocks.
// - Mode 01 starts a calibration instead of a conversion.
// - Calibration lasts about 80,000 clocks unless aborted.
// - Reset pin low, shutdown pin low or new start bit abort calibration.
// - Mode 10 finishes the current conversion, then powers down.
// - A new start bit wakes the device from software shutdown.
// - Mode 10 conversions reuse the previous acquisition length.
// - Shutdown entered by shutdown pin low or by software request.
// - Calibration survives shutdown.
// - First high bit clocked in is the start bit of the control word.
// - Result goes out MSB first, binary unipolar, two's complement bipolar.
// - Calibration strobe: internal low then high; external high then low.
// - After reset user outputs low, bipolar mode, internal clock.
`include "amsq_params.svh"
module amsq_top #(
  parameter int unsigned CAL_CYCLES = 80000,
  parameter int unsigned INT_DIV    = 40
) (
  input  logic        clk_sys_i,
  input  logic        rst_n_i,
  input  logic [4:0]  avs_address_i,
  input  logic        avs_read_i,
  input  logic        avs_write_i,
  input  logic [31:0] avs_writedata_i,
  input  logic [3:0]  avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic        avs_waitrequest_o,
  output logic        irq_o,
  input  logic        sclk_i,
  input  logic        cs_n_i,
  input  logic        din_i,
  output logic        dout_o,
  input  logic        power_down_pin_n_i,
  input  logic        reset_pin_n_i,
  input  logic [15:0] sample_data_i,
  output logic        sample_hold_o,
  output logic        progress_strobe_out_o,
  output logic        user_logic_out_0_o,
  output logic        user_logic_out_1_o,
  output logic        user_logic_out_2_o
);
  localparam int unsigned CW = $clog2(CAL_CYCLES);
  localparam int unsigned DW = $clog2(INT_DIV);

  amsq_pkg::amsq_state_t st_reg;
  amsq_pkg::amsq_ctrl_t  ctrl_reg;
  amsq_pkg::amsq_pins_t  pin_s;
  logic [7:0]    shreg_reg;
  logic [5:0]    cnt_reg;
  logic [3:0]    out_cnt_reg;
  logic [15:0]   out_sh_reg;
  logic [15:0]   res_reg;
  logic [CW-1:0] cal_cnt_reg;
  logic [DW-1:0] div_reg;
  logic          int_tick_reg;
  logic          sclk_d_reg;
  logic          acq_long_reg;
  logic          power_down_pin_n_pend_reg;
  logic          power_down_pin_n_sw_reg;
  logic          cal_valid_reg;
  logic          strobe_reg;
  logic          hold_reg;
  logic [3:0]    evt_reg;
  logic [3:0]    irq_st_reg;
  logic [3:0]    irq_msk_reg;
  logic          irq_reg;
  logic          link_en_reg;
  logic          waitreq_reg;
  logic [31:0]   rdata_reg;

  // Pins cross into the system clock before anything looks at them
  amsq_sync #(
    .W       (5),
    .RST_VAL (`AMSQ_PIN_RST)
  ) u_sync (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .async_i   ({reset_pin_n_i, power_down_pin_n_i, din_i, cs_n_i, sclk_i}),
    .sync_o    (pin_s)
  );

  // Serial clock edges, found on the synchronised level
  wire sclk_rise = pin_s.sclk & ~sclk_d_reg;
  wire sclk_fall = ~pin_s.sclk & sclk_d_reg;
  wire pdn_s     = pin_s.pdn_n;
  wire rstpin_s  = pin_s.rst_pin_n;
  wire in_recv   = (st_reg == amsq_pkg::ST_RECV);
  wire in_cal    = (st_reg == amsq_pkg::ST_CAL);

  // Start bit: first high data bit with select low, outside a control byte
  wire start_evt = sclk_rise & ~pin_s.cs_n & pin_s.din & ~in_recv & link_en_reg;

  // Conversion and calibration tick: serial clock or internal divider
  wire conv_tick = ctrl_reg.ext_clk ? sclk_fall : int_tick_reg;

  // Mode as seen at the end of acquisition in a short frame
  wire acq_m1    = shreg_reg[`AMSQ_ACQ_M1];
  wire acq_m0    = shreg_reg[`AMSQ_ACQ_M0];
  wire acq_cal   = ~acq_m1 & acq_m0;
  wire long_now  = acq_m1 & (acq_m0 | acq_long_reg);

  // Mode as seen in the complete control byte
  wire byte_m1   = shreg_reg[`AMSQ_POS_M1];
  wire byte_m0   = shreg_reg[`AMSQ_POS_M0];
  wire byte_cal  = ~byte_m1 & byte_m0;
  wire byte_ext  = shreg_reg[`AMSQ_POS_CLK];

  // Output coding: core delivers offset binary
  wire [15:0] code_bip = {~sample_data_i[15], sample_data_i[14:0]};
  wire        uni_acq  = shreg_reg[`AMSQ_ACQ_UNI];

  // Frame positions
  wire at_acq_s  = cnt_reg == 6'(`AMSQ_ACQ_SHORT - 1);
  wire at_acq_l  = cnt_reg == 6'(`AMSQ_ACQ_LONG - 1);
  wire at_byte   = cnt_reg == 6'(`AMSQ_CTRL_BITS - 1);
  wire at_conv_l = cnt_reg == 6'(`AMSQ_LONG_PER - `AMSQ_RES_BITS - 1);
  wire at_cal    = cal_cnt_reg == CW'(CAL_CYCLES - 1);
  wire at_last   = out_cnt_reg == 4'(`AMSQ_RES_BITS - 1);

  // Internal conversion clock as a one-cycle enable
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || div_reg == DW'(INT_DIV - 1)) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      int_tick_reg <= 1'b0;
      sclk_d_reg   <= 1'b0;
    end else begin
      int_tick_reg <= (div_reg == DW'(INT_DIV - 1));
      sclk_d_reg   <= pin_s.sclk;
    end
  end

  // Main sequencer. The reset pin acts like the system reset on control
  // state; the interrupt registers only clear on the system reset.
  always_ff @(posedge clk_sys_i) begin
    evt_reg  <= '0;
    hold_reg <= 1'b0;
    if (!rst_n_i || !rstpin_s) begin
      st_reg        <= amsq_pkg::ST_IDLE;
      ctrl_reg      <= '0;
      shreg_reg     <= '0;
      cnt_reg       <= '0;
      out_cnt_reg   <= '0;
      out_sh_reg    <= '0;
      acq_long_reg  <= 1'b0;
      power_down_pin_n_pend_reg <= 1'b0;
      power_down_pin_n_sw_reg   <= 1'b0;
      cal_valid_reg <= 1'b0;
      cal_cnt_reg   <= '0;
      strobe_reg    <= 1'b0;
      if (rst_n_i && in_cal) begin
        evt_reg[`AMSQ_EV_ABORT] <= 1'b1;
      end
    end else if (!pdn_s) begin
      // Pin shutdown wins over everything but reset
      if (st_reg != amsq_pkg::ST_POWER_DOWN_PIN_N) begin
        evt_reg[`AMSQ_EV_POWER_DOWN_PIN_N] <= 1'b1;
      end
      if (in_cal) begin
        evt_reg[`AMSQ_EV_ABORT] <= 1'b1;
      end
      st_reg      <= amsq_pkg::ST_POWER_DOWN_PIN_N;
      power_down_pin_n_sw_reg <= 1'b0;
    end else if (start_evt) begin
      // New control byte; aborts calibration, wakes from shutdown
      if (in_cal) begin
        evt_reg[`AMSQ_EV_ABORT] <= 1'b1;
      end
      st_reg      <= amsq_pkg::ST_RECV;
      shreg_reg   <= `AMSQ_START_SEED;
      cnt_reg     <= '0;
      strobe_reg  <= 1'b0;
      power_down_pin_n_sw_reg <= 1'b0;
    end else begin
      case (st_reg)
        amsq_pkg::ST_IDLE: begin
          cnt_reg <= '0;
        end
        amsq_pkg::ST_RECV: begin
          if (pin_s.cs_n) begin
            st_reg <= amsq_pkg::ST_IDLE;
          end else if (sclk_rise) begin
            shreg_reg <= {shreg_reg[6:0], pin_s.din};
          end else if (sclk_fall) begin
            cnt_reg <= cnt_reg + 1'b1;
            if (at_acq_s) begin
              // A calibration frame keeps the length that mode 10 reuses
              acq_long_reg <= acq_cal ? acq_long_reg : long_now;
              if (!long_now && !acq_cal) begin
                out_sh_reg <= uni_acq ? sample_data_i : code_bip;
                res_reg    <= uni_acq ? sample_data_i : code_bip;
                hold_reg   <= 1'b1;
              end
            end
            if (at_byte) begin
              ctrl_reg    <= amsq_pkg::amsq_ctrl_t'(shreg_reg[6:0]);
              out_cnt_reg <= '0;
              if (byte_cal) begin
                st_reg        <= amsq_pkg::ST_CAL;
                cal_cnt_reg   <= '0;
                cal_valid_reg <= 1'b0;
                strobe_reg    <= byte_ext;
              end else begin
                power_down_pin_n_pend_reg <= byte_m1 & ~byte_m0;
                if (acq_long_reg) begin
                  st_reg <= amsq_pkg::ST_CONV;
                end else begin
                  st_reg                 <= amsq_pkg::ST_OUT;
                  strobe_reg             <= 1'b1;
                  evt_reg[`AMSQ_EV_CONV] <= 1'b1;
                end
              end
            end
          end
        end
        amsq_pkg::ST_CONV: begin
          if (conv_tick) begin
            cnt_reg <= cnt_reg + 1'b1;
            if (at_acq_l) begin
              out_sh_reg <= ctrl_reg.polarity_select ? sample_data_i : code_bip;
              res_reg    <= ctrl_reg.polarity_select ? sample_data_i : code_bip;
              hold_reg   <= 1'b1;
            end
            if (at_conv_l) begin
              st_reg                 <= amsq_pkg::ST_OUT;
              strobe_reg             <= 1'b1;
              evt_reg[`AMSQ_EV_CONV] <= 1'b1;
            end
          end
        end
        amsq_pkg::ST_OUT: begin
          // Result shifts out while the host shifts dummy bits in
          if (sclk_fall) begin
            out_sh_reg  <= {out_sh_reg[14:0], 1'b0};
            out_cnt_reg <= out_cnt_reg + 1'b1;
            if (ctrl_reg.ext_clk) begin
              strobe_reg <= 1'b0;
            end
            if (at_last) begin
              if (power_down_pin_n_pend_reg) begin
                st_reg                 <= amsq_pkg::ST_POWER_DOWN_PIN_N;
                power_down_pin_n_sw_reg            <= 1'b1;
                evt_reg[`AMSQ_EV_POWER_DOWN_PIN_N] <= 1'b1;
              end else begin
                st_reg <= amsq_pkg::ST_IDLE;
              end
            end
          end
        end
        amsq_pkg::ST_CAL: begin
          if (conv_tick) begin
            cal_cnt_reg <= cal_cnt_reg + 1'b1;
            if (at_cal) begin
              st_reg                    <= amsq_pkg::ST_IDLE;
              cal_valid_reg             <= 1'b1;
              strobe_reg                <= ~ctrl_reg.ext_clk;
              evt_reg[`AMSQ_EV_CALDONE] <= 1'b1;
            end
          end
        end
        amsq_pkg::ST_POWER_DOWN_PIN_N: begin
          // Pin shutdown ends when the pin rises; software waits for a start
          if (!power_down_pin_n_sw_reg) begin
            st_reg <= amsq_pkg::ST_IDLE;
          end
        end
        default: begin
          st_reg <= amsq_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Bus decode; one wait state on every access
  wire        bus_req = avs_read_i | avs_write_i;
  wire        wr_acc  = avs_write_i & ~waitreq_reg & avs_byteenable_i[0];
  wire        sel_ctl = avs_address_i == `AMSQ_REG_CTRL;
  wire        sel_sta = avs_address_i == `AMSQ_REG_STAT;
  wire        sel_ist = avs_address_i == `AMSQ_REG_IRQST;
  wire        sel_msk = avs_address_i == `AMSQ_REG_IRQMSK;
  wire        sel_res = avs_address_i == `AMSQ_REG_RESULT;
  wire [31:0] stat_w  = {19'h0, strobe_reg, ctrl_reg.user_out, ctrl_reg.ext_clk,
                         ctrl_reg.polarity_select, cal_valid_reg, st_reg};
  wire [31:0] rd_mux  = sel_ctl ? {31'h0, link_en_reg} :
                        sel_sta ? stat_w :
                        sel_ist ? {28'h0, irq_st_reg} :
                        sel_msk ? {28'h0, irq_msk_reg} :
                        sel_res ? {16'h0, res_reg} : 32'h0;

  // An event in the clearing cycle survives the clear
  wire [3:0] irq_clr     = (wr_acc && sel_ist) ? avs_writedata_i[3:0] : 4'h0;
  wire [3:0] irq_st_next = (irq_st_reg & ~irq_clr) | evt_reg;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      waitreq_reg <= 1'b1;
      rdata_reg   <= '0;
    end else begin
      waitreq_reg <= ~(bus_req & waitreq_reg);
      if (bus_req && waitreq_reg) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      link_en_reg <= `AMSQ_CTRL_RST;
      irq_msk_reg <= '0;
    end else if (wr_acc) begin
      if (sel_ctl) begin
        link_en_reg <= avs_writedata_i[0];
      end
      if (sel_msk) begin
        irq_msk_reg <= avs_writedata_i[3:0];
      end
    end
  end

  // Level interrupt, one cycle behind the status register
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      irq_st_reg <= '0;
      irq_reg    <= 1'b0;
    end else begin
      irq_st_reg <= irq_st_next;
      irq_reg    <= |(irq_st_reg & irq_msk_reg);
    end
  end

  assign avs_readdata_o        = rdata_reg;
  assign avs_waitrequest_o     = waitreq_reg;
  assign irq_o                 = irq_reg;
  assign dout_o                = out_sh_reg[15];
  assign sample_hold_o         = hold_reg;
  assign progress_strobe_out_o = strobe_reg;
  assign user_logic_out_0_o    = ctrl_reg.user_out[0];
  assign user_logic_out_1_o    = ctrl_reg.user_out[1];
  assign user_logic_out_2_o    = ctrl_reg.user_out[2];

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  wire quiet = rstpin_s & pdn_s & ~start_evt;

  a_start_bit: assert property (st_reg == amsq_pkg::ST_IDLE && start_evt && rstpin_s && pdn_s
    |=> st_reg == amsq_pkg::ST_RECV && shreg_reg == `AMSQ_START_SEED)
    else $error("start bit not taken");

  a_wake_start: assert property (st_reg == amsq_pkg::ST_POWER_DOWN_PIN_N && start_evt && rstpin_s && pdn_s
    |=> st_reg == amsq_pkg::ST_RECV)
    else $error("no wake on start bit");

  a_pin_power_down_pin_n: assert property (rstpin_s && !pdn_s |=> st_reg == amsq_pkg::ST_POWER_DOWN_PIN_N)
    else $error("shutdown pin ignored");

  a_cal_abort: assert property (in_cal && rstpin_s && (!pdn_s || start_evt)
    |=> !in_cal && evt_reg[`AMSQ_EV_ABORT])
    else $error("calibration not aborted");

  a_cal_strobe: assert property ($rose(in_cal) |-> strobe_reg == ctrl_reg.ext_clk)
    else $error("wrong strobe at calibration start");

  a_cal_length: assert property (in_cal && conv_tick && at_cal && quiet
    |=> st_reg == amsq_pkg::ST_IDLE && cal_valid_reg && strobe_reg != ctrl_reg.ext_clk)
    else $error("calibration end wrong");

  a_cal_start: assert property (in_recv && sclk_fall && at_byte && byte_cal && quiet
    && !pin_s.cs_n |=> in_cal)
    else $error("calibration not started");

  a_short_len: assert property ($rose(st_reg == amsq_pkg::ST_OUT) && !acq_long_reg
    |-> cnt_reg == 6'(`AMSQ_SHORT_PER - `AMSQ_RES_BITS))
    else $error("short period wrong");

  a_long_len: assert property ($rose(st_reg == amsq_pkg::ST_OUT) && acq_long_reg
    |-> cnt_reg == 6'(`AMSQ_LONG_PER - `AMSQ_RES_BITS))
    else $error("long period wrong");

  sequence s_last_bit;
    st_reg == amsq_pkg::ST_OUT && sclk_fall && at_last && power_down_pin_n_pend_reg && quiet;
  endsequence
  sequence s_sw_down;
    st_reg == amsq_pkg::ST_POWER_DOWN_PIN_N && power_down_pin_n_sw_reg ##1 st_reg == amsq_pkg::ST_POWER_DOWN_PIN_N;
  endsequence
  a_sw_power_down_pin_n: assert property (s_last_bit ##1 pdn_s && rstpin_s && !start_evt
    |-> s_sw_down)
    else $error("software shutdown not entered");

  a_rst_pin: assert property (!rstpin_s |=> ctrl_reg == '0 && !strobe_reg
    && !user_logic_out_0_o && !user_logic_out_2_o)
    else $error("reset pin state wrong");
endmodule

// *** test/amsq_host_model.sv ***
// Behavioural serial host on the far side of the sequencer's link.
// Assumes the bench calls its tasks one at a time; the serial clock idles low.
module amsq_host_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o,
  input  logic dout_i
);
  timeunit 1ns;
  timeprecision 100ps;

  // Falls of the serial clock since the frame opened
  int fall_cnt;

  // Clock stands still and chip select is high outside frames
  initial begin
    sclk_o   = 1'b0;
    cs_n_o   = 1'b1;
    din_o    = 1'b0;
    fall_cnt = 0;
  end

  // Full duplex shift, MSB first, 64 ns period; a leading one is the start bit
  task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
    rx     = '0;
    cs_n_o = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      din_o  = tx[i];
      #32;
      rx     = {rx[30:0], dout_i};
      sclk_o = 1'b1;
      #32;
      sclk_o = 1'b0;
      fall_cnt++;
    end
  endtask

  // Close the frame; the released data line flips so no stale level lingers
  task automatic idle();
    #32;
    cs_n_o   = 1'b1;
    din_o    = ~din_o;
    fall_cnt = 0;
  endtask
endmodule

// *** test/amsq_top_tb_top.sv ***
// Self-checking bench of the serial mode sequencer with Avalon-MM registers.
// Assumes the host model drives the link; calibration is shortened by parameters.
`include "amsq_params.svh"
module amsq_top_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int CAL = 40;
  localparam int DIV = 4;

  logic        clk_sys_i, rst_n_i, avs_read_i, avs_write_i, avs_waitrequest_o, irq_o;
  logic        sclk_i, cs_n_i, din_i, dout_o, power_down_pin_n_i, reset_pin_n_i;
  logic        sample_hold_o, progress_strobe_out_o;
  logic        user_logic_out_0_o, user_logic_out_1_o, user_logic_out_2_o;
  logic [4:0]  avs_address_i;
  logic [3:0]  avs_byteenable_i;
  logic [15:0] sample_data_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, rd, rx, seed;
  int          failures = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          hold_at, n;

  amsq_top #(.CAL_CYCLES(CAL), .INT_DIV(DIV)) amsq_top_i (
    .clk_sys_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
    .irq_o, .sclk_i, .cs_n_i, .din_i, .dout_o, .power_down_pin_n_i,
    .reset_pin_n_i, .sample_data_i, .sample_hold_o, .progress_strobe_out_o,
    .user_logic_out_0_o, .user_logic_out_1_o, .user_logic_out_2_o
  );
  amsq_host_model amsq_host_model_i (
    .sclk_o (sclk_i),
    .cs_n_o (cs_n_i),
    .din_o  (din_i),
    .dout_i (dout_o)
  );

  // 200 MHz system clock
  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  // Hang guard, far above the few thousand cycles the run needs
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      failures++;
      stop_test();
    end
  end

  // Which serial fall the sample was taken on
  always @(posedge clk_sys_i) begin
    if (sample_hold_o === 1'b1) hold_at <= amsq_host_model_i.fall_cnt;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task stop_test();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic wt(input int k);
    repeat (k) @(posedge clk_sys_i);
  endtask

  // One bus access; an edge passes after release so requests never merge
  task automatic bus(input logic we, input logic [4:0] a, input logic [31:0] wd);
    avs_address_i   <= a;
    avs_writedata_i <= wd;
    avs_write_i     <= we;
    avs_read_i      <= !we;
    @(posedge clk_sys_i);
    // Only the hang guard ends a wait that never sees the answer
    while (avs_waitrequest_o !== 1'b0) begin
      @(posedge clk_sys_i);
    end
    rd = avs_readdata_o;
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  task automatic rchk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e,
                      input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, rd & m, e);
  endtask

  // External-clock conversion frame; lng says whether acquisition is long
  task automatic conv(input logic uni, input logic [1:0] md, input logic lng,
                      input logic [2:0] p);
    logic [15:0] s, e;
    seed = xs(seed);
    s    = seed[15:0];
    e    = uni ? s : s ^ 16'h8000;
    sample_data_i <= s;
    hold_at = 0;
    wt(1);
    // The user output levels ride in this byte and land at its eighth falling edge
    amsq_host_model_i.xfer(8, {24'h0, 1'b1, uni, 1'b1, md, p}, rx);
    wt(8);
    chk("strobe_byte1", progress_strobe_out_o, !lng);
    chk("user_outs", {user_logic_out_2_o, user_logic_out_1_o, user_logic_out_0_o}, p);
    if (!lng) begin
      chk("dout_msb", dout_o, e[15]);
    end else begin
      amsq_host_model_i.xfer(8, 32'h0, rx);
      wt(8);
      chk("strobe_byte2", progress_strobe_out_o, 1'b1);
    end
    amsq_host_model_i.xfer(16, 32'h0, rx);
    chk("result_bits", rx[15:0], e);
    chk("hold_fall", hold_at, lng ? 14 : 6);
    amsq_host_model_i.idle();
    wt(8);
    rchk(`AMSQ_REG_RESULT, 32'hffff, e, "result_reg");
    rchk(`AMSQ_REG_STAT, 32'h3f, md == 2'b10 ? 32'h20 : 32'h01, "end_state");
  endtask

  // Internal-clock calibration request, user outputs p
  task automatic cal_start(input logic [2:0] p);
    amsq_host_model_i.xfer(8, {24'h0, 8'h88 | p}, rx);
    amsq_host_model_i.idle();
    wt(8);
  endtask

  // Main sequence
  initial begin
    rst_n_i = 1'b0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_address_i = 5'h00;
    avs_writedata_i = 32'h0;
    avs_byteenable_i = 4'h1;
    sample_data_i = 16'h0000;
    power_down_pin_n_i = 1'b1;
    reset_pin_n_i = 1'b1;
    seed = 32'h91ec1c6f;
    wt(4);
    rst_n_i <= 1'b1;
    wt(4);
    chk("pins_rst", {user_logic_out_2_o, user_logic_out_1_o, user_logic_out_0_o, irq_o}, 0);
    rchk(`AMSQ_REG_CTRL, 32'h1, 32'h1, "ctrl_rst");
    rchk(`AMSQ_REG_STAT, 32'h1fff, 32'h001, "stat_rst");
    rchk(`AMSQ_REG_IRQMSK, 32'hf, 32'h0, "mask_rst");
    rchk(5'h14, 32'hffffffff, 32'h0, "unmapped");
    // Calibration: strobe low while running, high at the end
    cal_start(3'b000);
    chk("cal_strobe", progress_strobe_out_o, 1'b0);
    rchk(`AMSQ_REG_STAT, 32'h3f, 32'h10, "cal_state");
    n = 0;
    while (progress_strobe_out_o !== 1'b1 && n < 2000) begin
      wt(1);
      n++;
    end
    chk("cal_len", n > CAL * DIV - 40 && n < CAL * DIV + 20, 1'b1);
    rchk(`AMSQ_REG_IRQST, 32'h2, 32'h2, "ev_cal_done");
    // Recalibrate on the serial clock that the conversions below run on
    amsq_host_model_i.xfer(8, 32'ha8, rx);
    wt(8);
    chk("cal_strobe_ext", progress_strobe_out_o, 1'b1);
    amsq_host_model_i.xfer(32, 32'h0, rx);
    chk("cal_run_ext", progress_strobe_out_o, 1'b1);
    amsq_host_model_i.xfer(CAL - 32, 32'h0, rx);
    amsq_host_model_i.idle();
    wt(8);
    chk("cal_end_ext", progress_strobe_out_o, 1'b0);
    rchk(`AMSQ_REG_STAT, 32'h7f, 32'h41, "cal_ext_done");
    // Short and long, both polarities; the last one runs with the mask off
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, `AMSQ_REG_IRQMSK, i == 3 ? 32'h0 : 32'hf);
      bus(1'b1, `AMSQ_REG_IRQST, 32'hf);
      seed = xs(seed);
      conv(i[0], i[1] ? 2'b11 : 2'b00, i[1], seed[2:0]);
      chk("irq_level", irq_o, i != 3);
      rchk(`AMSQ_REG_IRQST, 32'h1, 32'h1, "ev_conv");
      bus(1'b1, `AMSQ_REG_IRQST, 32'hf);
      wt(3);
      chk("irq_clear", irq_o, 1'b0);
    end
    // Software shutdown after a long frame, then wake by a start bit
    conv(1'b0, 2'b10, 1'b1, 3'b010);
    rchk(`AMSQ_REG_IRQST, 32'h8, 32'h8, "ev_power_down_pin_n");
    conv(1'b0, 2'b00, 1'b0, 3'b001);
    rchk(`AMSQ_REG_STAT, 32'h40, 32'h40, "cal_kept");
    // Shutdown pin
    power_down_pin_n_i <= 1'b0;
    wt(10);
    rchk(`AMSQ_REG_STAT, 32'h3f, 32'h20, "pin_power_down_pin_n");
    power_down_pin_n_i <= 1'b1;
    wt(10);
    rchk(`AMSQ_REG_STAT, 32'h3f, 32'h01, "pin_wake");
    // Abort a calibration by start bit, shutdown pin and reset pin
    for (int c = 0; c < 3; c++) begin
      bus(1'b1, `AMSQ_REG_IRQST, 32'hf);
      cal_start(3'b101);
      wt(20);
      if (c == 0) begin
        conv(1'b0, 2'b00, 1'b0, 3'b011);
      end else if (c == 1) begin
        power_down_pin_n_i <= 1'b0;
        wt(10);
        power_down_pin_n_i <= 1'b1;
        wt(10);
      end else begin
        reset_pin_n_i <= 1'b0;
        wt(10);
        reset_pin_n_i <= 1'b1;
        wt(10);
      end
      rchk(`AMSQ_REG_IRQST, 32'h4, 32'h4, "ev_abort");
      rchk(`AMSQ_REG_STAT, 32'h40, 32'h0, "cal_dropped");
    end
    chk("uo_pin_rst", {user_logic_out_2_o, user_logic_out_1_o, user_logic_out_0_o}, 0);
    rchk(`AMSQ_REG_STAT, 32'hfff, 32'h001, "stat_pin_rst");
    // Byte lane 0 gates writes; start bits are ignored while the link is off
    avs_byteenable_i <= 4'h0;
    bus(1'b1, `AMSQ_REG_CTRL, 32'h0);
    avs_byteenable_i <= 4'h1;
    rchk(`AMSQ_REG_CTRL, 32'h1, 32'h1, "ctrl_be_off");
    bus(1'b1, `AMSQ_REG_CTRL, 32'h0);
    cal_start(3'b111);
    rchk(`AMSQ_REG_STAT, 32'hfff, 32'h001, "link_off");
    bus(1'b1, `AMSQ_REG_CTRL, 32'h1);
    stop_test();
  end
endmodule
